// ### rtm_pkg.sv
// Shared constants and types of the retimer control register block
package rtm_pkg;
    localparam int MAX_CH = 4;
    localparam int EYE_W = 4;
    // Shared register offsets
    localparam logic [7:0] SH_REV_ID = 8'h01;
    localparam logic [7:0] SH_CTRL = 8'h04;
    localparam logic [7:0] SH_STAT = 8'h05;
    localparam logic [7:0] SH_CH_SEL = 8'hff;
    // Channel register offsets
    localparam logic [7:0] CH_SRST = 8'h00;
    localparam logic [7:0] CH_LSIRQ = 8'h01;
    localparam logic [7:0] CH_CDROVR = 8'h0a;
    localparam logic [7:0] CH_EYEST = 8'h30;
    localparam logic [7:0] CH_ADAPT = 8'h31;
    localparam logic [7:0] CH_EYETHR = 8'h32;
    localparam logic [7:0] CH_EYEEN = 8'h36;
    // Field positions
    localparam int CTRL_SHRST_B = 6;
    localparam int CTRL_MRST_B = 5;
    localparam int CTRL_TRIG_B = 4;
    localparam int STAT_DIS_B = 7;
    localparam int STAT_DONE_B = 4;
    localparam int SEL_PAGE_B = 2;
    localparam int SRST_B = 2;
    localparam int LS_LOCK_B = 4;
    localparam int LS_SIG_B = 0;
    localparam int OVR_EN_B = 3;
    localparam int OVR_RST_B = 2;
    localparam int EYE_FLAG_B = 4;
    localparam int ADAPT_LSB = 5;
    localparam int EYE_EN_B = 6;
    // Reset values
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam logic [1:0] ADAPT_RST = 2'h0;
    localparam logic [7:0] EYETHR_RST = 8'h00;
    // EEPROM loader states
    typedef enum logic [2:0] {
        LD_ARMED = 3'b001,
        LD_BUSY = 3'b010,
        LD_DONE = 3'b100
    } rtm_ld_state_t;
endpackage

// ### rtm_if.sv
// Carriers between the register top, the channels and the EEPROM loader
`timescale 1ns/1ps
interface rtm_chan_if;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic lock;
    logic sig;
    logic [3:0] horizontal_eye_opening;
    logic [3:0] vertical_eye_opening;
    logic irq;
    logic cdr_rst;
    logic restart;
    logic [1:0] adapt;
    modport top(output wr, rd, addr, wdata, lock, sig, horizontal_eye_opening, vertical_eye_opening, input rdata, irq, cdr_rst, restart, adapt);
    modport chan(input wr, rd, addr, wdata, lock, sig, horizontal_eye_opening, vertical_eye_opening, output rdata, irq, cdr_rst, restart, adapt);
endinterface
interface rtm_ld_if;
    logic strap_master;
    logic req_low;
    logic mrst;
    logic trig;
    logic dis;
    logic ee_done;
    logic ee_start;
    logic done;
    modport top(output strap_master, req_low, mrst, trig, dis, ee_done, input ee_start, done);
    modport ldr(input strap_master, req_low, mrst, trig, dis, ee_done, output ee_start, done);
endinterface

// ### rtm_channel.sv
// One channel: soft reset, CDR reset override and read-to-clear interrupt flags
`timescale 1ns/1ps
module rtm_channel import rtm_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    rtm_chan_if.chan ch
);
    typedef struct packed {
        logic ovr_en;
        logic ovr_rst;
        logic [1:0] adapt;
        logic [7:0] thr;
        logic eye_en;
        logic lock_f;
        logic sig_f;
        logic eye_f;
        logic lock_d;
        logic sig_d;
        logic held_d;
        logic cdr_rst;
        logic restart;
    } rtm_ch_st_t;
    localparam rtm_ch_st_t CH_ST_RST = '{adapt: ADAPT_RST, thr: EYETHR_RST, default: '0};
    rtm_ch_st_t r, n;
    logic held, lock_ev, sig_ev, eye_ev;

    always_comb begin
        held = r.ovr_en & r.ovr_rst;
        lock_ev = r.lock_d & ~ch.lock;
        sig_ev = r.sig_d & ~ch.sig;
        eye_ev = r.eye_en & ((ch.horizontal_eye_opening < r.thr[7:4]) | (ch.vertical_eye_opening < r.thr[3:0]));
        n = r;
        n.lock_d = ch.lock;
        n.sig_d = ch.sig;
        n.held_d = held;
        n.cdr_rst = held;
        n.restart = r.held_d & ~held & ch.sig;
        if (ch.rd && ch.addr == CH_LSIRQ) begin
            n.lock_f = 1'b0;
            n.sig_f = 1'b0;
        end
        if (ch.rd && ch.addr == CH_EYEST) begin
            n.eye_f = 1'b0;
        end
        if (ch.wr) begin
            unique case (ch.addr)
                CH_SRST: if (ch.wdata[SRST_B]) begin
                    n.ovr_en = 1'b0;
                    n.ovr_rst = 1'b0;
                    n.adapt = ADAPT_RST;
                    n.thr = EYETHR_RST;
                    n.eye_en = 1'b0;
                    n.lock_f = 1'b0;
                    n.sig_f = 1'b0;
                    n.eye_f = 1'b0;
                end
                CH_CDROVR: begin
                    n.ovr_en = ch.wdata[OVR_EN_B];
                    n.ovr_rst = ch.wdata[OVR_RST_B];
                end
                CH_ADAPT: n.adapt = ch.wdata[ADAPT_LSB+:2];
                CH_EYETHR: n.thr = ch.wdata;
                CH_EYEEN: n.eye_en = ch.wdata[EYE_EN_B];
                default: ;
            endcase
        end
        // Events win over a clear in the same cycle
        if (lock_ev) n.lock_f = 1'b1;
        if (sig_ev) n.sig_f = 1'b1;
        if (eye_ev) n.eye_f = 1'b1;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) r <= CH_ST_RST;
        else r <= n;
    end

    always_comb begin
        unique case (ch.addr)
            CH_LSIRQ: ch.rdata = {3'h0, r.lock_f, 3'h0, r.sig_f};
            CH_CDROVR: ch.rdata = {4'h0, r.ovr_en, r.ovr_rst, 2'h0};
            CH_EYEST: ch.rdata = {3'h0, r.eye_f, 4'h0};
            CH_ADAPT: ch.rdata = {1'b0, r.adapt, 5'h00};
            CH_EYETHR: ch.rdata = r.thr;
            CH_EYEEN: ch.rdata = {1'b0, r.eye_en, 6'h00};
            default: ch.rdata = 8'h00;
        endcase
    end
    assign ch.irq = r.lock_f | r.sig_f | r.eye_f;
    assign ch.cdr_rst = r.cdr_rst;
    assign ch.restart = r.restart;
    assign ch.adapt = r.adapt;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_release;
        held ##1 (!held && ch.sig);
    endsequence
    chan_srst_a: assert property (ch.wr && ch.addr == CH_SRST && ch.wdata[SRST_B] |=>
        !r.ovr_en && !r.eye_en && r.thr == EYETHR_RST) else $error("channel soft reset missed");
    cdr_hold_a: assert property (held |-> ##1 ch.cdr_rst) else $error("cdr not held");
    cdr_restart_a: assert property (s_release |=> ch.restart) else $error("no restart");
    lock_loss_a: assert property (lock_ev |=> r.lock_f && ch.irq) else $error("lock loss lost");
    eye_flag_a: assert property (eye_ev |=> r.eye_f && ch.irq) else $error("eye flag lost");
    ls_clear_a: assert property (ch.rd && ch.addr == CH_LSIRQ && !lock_ev && !sig_ev
        |=> !r.lock_f && !r.sig_f) else $error("status not cleared");
    eye_clear_a: assert property (ch.rd && ch.addr == CH_EYEST && !eye_ev |=> !r.eye_f)
        else $error("eye flag not cleared");
endmodule // rtm_channel

// ### rtm_loader.sv
// EEPROM configuration load sequencer
`timescale 1ns/1ps
module rtm_loader import rtm_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    rtm_ld_if.ldr ld
);
    typedef struct packed {
        rtm_ld_state_t st;
        logic start;
        logic done;
    } rtm_ld_st_t;
    rtm_ld_st_t r, n;
    logic go;

    always_comb begin
        go = !ld.dis && (ld.trig || (ld.strap_master && ld.req_low));
        n = r;
        n.start = 1'b0;
        unique case (r.st)
            LD_ARMED: if (!ld.mrst && go) begin
                n.st = LD_BUSY;
                n.start = 1'b1;
            end
            LD_BUSY: if (ld.ee_done) begin
                n.st = LD_DONE;
                n.done = 1'b1;
            end
            LD_DONE: if (ld.mrst) begin
                n.st = LD_ARMED;
                n.done = 1'b0;
            end
            default: n.st = LD_ARMED;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) r <= '{st: LD_ARMED, start: 1'b0, done: 1'b0};
        else r <= n;
    end
    assign ld.ee_start = r.start;
    assign ld.done = r.done;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    pin_load_a: assert property (r.st == LD_ARMED && !ld.mrst && !ld.dis && ld.strap_master
        && ld.req_low |=> ld.ee_start && r.st == LD_BUSY) else $error("pin load not started");
    trig_load_a: assert property (r.st == LD_ARMED && !ld.mrst && !ld.dis && ld.trig
        |=> ld.ee_start) else $error("trigger load not started");
    done_hold_a: assert property (r.st == LD_DONE && !ld.mrst |=> r.st == LD_DONE && !ld.ee_start)
        else $error("reload without reset");
    dis_block_a: assert property (r.st == LD_ARMED && ld.dis |=> !ld.ee_start)
        else $error("load despite disable");
    done_flag_a: assert property (r.st == LD_BUSY && ld.ee_done |=> ld.done) else $error("done lost");
endmodule // rtm_loader

// ### rtm_ctrl_regs.sv
// Retimer shared and per-channel control, EEPROM load control and interrupt line
`timescale 1ns/1ps
module rtm_ctrl_regs import rtm_pkg::*; #(
    parameter int NUM_CH = 4,
    parameter logic [7:0] REV_ID = 8'h3c // Arbitrary value
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic bus_role_strap_i,
    input wire logic load_req_n_i,
    input wire logic ee_done_i,
    output logic ee_start_o,
    input wire logic [NUM_CH-1:0] lock_i,
    input wire logic [NUM_CH-1:0] sig_det_i,
    input wire logic [NUM_CH*EYE_W-1:0] horizontal_eye_opening_i,
    input wire logic [NUM_CH*EYE_W-1:0] vertical_eye_opening_i,
    output logic [NUM_CH-1:0] cdr_reset_o,
    output logic [NUM_CH-1:0] cdr_restart_o,
    output logic [NUM_CH*2-1:0] adapt_mode_o,
    output logic irq_n_o,
    output logic irq_n_oe_o
);
    if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_chk
        $error("NUM_CH must be 1 to 4");
    end

    typedef struct packed {
        logic [7:0] sel;
        logic mrst;
        logic trig;
        logic dis;
        logic [7:0] rdata;
        logic rvalid;
        logic [1:0] strap_s;
        logic [1:0] strap_age;
        logic strap_taken;
        logic strap_master;
        logic [1:0] req_s;
        logic [NUM_CH-1:0] lock_s1;
        logic [NUM_CH-1:0] lock_s2;
        logic [NUM_CH-1:0] sig_s1;
        logic [NUM_CH-1:0] sig_s2;
        logic irq_oe;
    } rtm_top_st_t;

    rtm_top_st_t r, n;
    logic [NUM_CH-1:0][7:0] ch_rdata;
    logic [NUM_CH-1:0] ch_irq;
    logic [MAX_CH-1:0] irq_flags;
    logic page_on;
    logic ch_hit;
    logic ld_done;
    rtm_ld_if lif();

    // Channel page open for every offset but the select register
    assign page_on = r.sel[SEL_PAGE_B] && reg_addr_i != SH_CH_SEL;
    assign ch_hit = 32'(r.sel[1:0]) < NUM_CH;
    assign irq_flags = MAX_CH'(ch_irq);

    function automatic logic [7:0] shared_read(
        input logic [7:0] addr,
        input rtm_top_st_t s,
        input logic done,
        input logic [MAX_CH-1:0] flags
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            SH_REV_ID: v = REV_ID;
            SH_CTRL: begin
                v[CTRL_MRST_B] = s.mrst;
                v[CTRL_TRIG_B] = s.trig;
            end
            SH_STAT: begin
                v[STAT_DIS_B] = s.dis;
                v[STAT_DONE_B] = done;
                v[MAX_CH-1:0] = flags;
            end
            SH_CH_SEL: v = s.sel;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        n = r;
        n.rvalid = 1'b0;
        // Pin synchronisers
        n.strap_s = {r.strap_s[0], bus_role_strap_i};
        n.req_s = {r.req_s[0], load_req_n_i};
        n.lock_s1 = lock_i;
        n.lock_s2 = r.lock_s1;
        n.sig_s1 = sig_det_i;
        n.sig_s2 = r.sig_s1;
        // Strap caught once the synchroniser has filled after reset
        n.strap_age = {r.strap_age[0], 1'b1};
        if (r.strap_age[1] && !r.strap_taken) begin
            n.strap_taken = 1'b1;
            n.strap_master = r.strap_s[1];
        end
        // Open-drain line driven while any flag is pending
        n.irq_oe = |ch_irq;
        if (reg_wr_i && !page_on) begin
            unique case (reg_addr_i)
                SH_CH_SEL: n.sel = reg_wdata_i;
                SH_CTRL: begin
                    if (reg_wdata_i[CTRL_SHRST_B]) begin
                        n.sel = SEL_RST;
                        n.mrst = 1'b0;
                        n.trig = 1'b0;
                        n.dis = 1'b0;
                    end else begin
                        n.mrst = reg_wdata_i[CTRL_MRST_B];
                        n.trig = reg_wdata_i[CTRL_TRIG_B];
                    end
                end
                SH_STAT: n.dis = reg_wdata_i[STAT_DIS_B];
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            n.rvalid = 1'b1;
            if (page_on) begin
                n.rdata = ch_hit ? ch_rdata[r.sel[1:0]] : 8'h00;
            end else begin
                n.rdata = shared_read(reg_addr_i, r, ld_done, irq_flags);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '{sel: SEL_RST, req_s: 2'b11, default: '0};
        end else begin
            r <= n;
        end
    end

    // Per-channel register sets
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        rtm_chan_if cif();
        assign cif.wr = reg_wr_i && page_on && r.sel[1:0] == 2'(g);
        assign cif.rd = reg_rd_i && page_on && r.sel[1:0] == 2'(g);
        assign cif.addr = reg_addr_i;
        assign cif.wdata = reg_wdata_i;
        assign cif.lock = r.lock_s2[g];
        assign cif.sig = r.sig_s2[g];
        assign cif.horizontal_eye_opening = horizontal_eye_opening_i[g*EYE_W+:EYE_W];
        assign cif.vertical_eye_opening = vertical_eye_opening_i[g*EYE_W+:EYE_W];
        rtm_channel u_channel (
            .clk_i(clk_sys_i),
            .rstn_i(rstn_i),
            .ch(cif.chan)
        );
        assign ch_rdata[g] = cif.rdata;
        assign ch_irq[g] = cif.irq;
        assign cdr_reset_o[g] = cif.cdr_rst;
        assign cdr_restart_o[g] = cif.restart;
        assign adapt_mode_o[g*2+:2] = cif.adapt;
    end

    // EEPROM loader
    assign lif.strap_master = r.strap_master;
    assign lif.req_low = !r.req_s[1];
    assign lif.mrst = r.mrst;
    assign lif.trig = r.trig;
    assign lif.dis = r.dis;
    assign lif.ee_done = ee_done_i;
    assign ld_done = lif.done;
    rtm_loader u_loader (
        .clk_i(clk_sys_i),
        .rstn_i(rstn_i),
        .ld(lif.ldr)
    );

    assign ee_start_o = lif.ee_start;
    assign reg_rdata_o = r.rdata;
    assign reg_rvalid_o = r.rvalid;
    assign irq_n_o = 1'b0;
    assign irq_n_oe_o = r.irq_oe;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_shared_wr(logic [7:0] a);
        reg_wr_i && !page_on && reg_addr_i == a;
    endsequence

    shrst_clear_a: assert property (s_shared_wr(SH_CTRL) and reg_wdata_i[CTRL_SHRST_B]
        |=> !r.mrst && !r.trig && !r.dis && r.sel == SEL_RST) else $error("shared reset missed");
    shrst_read_a: assert property (reg_rd_i && !page_on && reg_addr_i == SH_CTRL
        |=> !reg_rdata_o[CTRL_SHRST_B]) else $error("shared reset bit not self-clearing");
    revid_read_a: assert property (reg_rd_i && !page_on && reg_addr_i == SH_REV_ID
        |=> reg_rvalid_o && reg_rdata_o == REV_ID) else $error("bad revision read");
    mrst_keep_a: assert property (r.mrst && !(reg_wr_i && !page_on && reg_addr_i == SH_CTRL)
        |=> r.mrst) else $error("loader reset bit cleared itself");
    stat_bits_a: assert property (reg_rd_i && !page_on && reg_addr_i == SH_STAT
        |=> reg_rdata_o[MAX_CH-1:0] == $past(irq_flags)) else $error("channel flags wrong");
    irq_drive_a: assert property ((|ch_irq) |=> irq_n_oe_o && !irq_n_o)
        else $error("interrupt line not pulled");
    irq_release_a: assert property (!(|ch_irq) |=> !irq_n_oe_o) else $error("line held");
    lock_path_a: assert property ($fell(r.lock_s2[0]) |-> ##1 ch_irq[0] ##1 irq_n_oe_o)
        else $error("lock loss did not reach line");
endmodule // rtm_ctrl_regs

// ### rtm_ee_model.sv
// Behavioural EEPROM read engine answering load starts
`timescale 1ns/1ps
module rtm_ee_model (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ee_start_i,
    input wire logic [3:0] lat_i,
    output logic ee_done_o
);
    logic [3:0] cnt_reg;
    logic busy_reg;
    // Done pulse a programmable number of cycles after each start
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            ee_done_o <= 1'b0;
        end else begin
            ee_done_o <= 1'b0;
            if (ee_start_i) begin
                busy_reg <= 1'b1;
                cnt_reg <= lat_i;
            end else if (busy_reg) begin
                if (cnt_reg == 4'h0) begin
                    busy_reg <= 1'b0;
                    ee_done_o <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 4'h1;
                end
            end
        end
    end
endmodule // rtm_ee_model

// ### tb_top.sv
// Self-checking bench of the retimer control register block
`timescale 1ns/1ps
module tb_top;
    import rtm_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h5a; // Arbitrary value
    logic clk_sys_i, rstn_i, reg_wr_i, reg_rd_i, role_strap, req_n, ee_done, ee_start, rvalid, irq_n, irq_oe;
    logic [7:0] addr, wdata, rdata, rd_val, adapt;
    logic [3:0] lock, sig, cdr_rst, restart, lat;
    logic [15:0] horizontal_eye_opening, vertical_eye_opening;
    logic [1:0] ch;
    logic [31:0] rng;
    int mismatches, n_tests, starts, rs;

    rtm_ctrl_regs #(.NUM_CH(4), .REV_ID(ID_VAL)) u_dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .bus_role_strap_i(role_strap), .load_req_n_i(req_n), .ee_done_i(ee_done), .ee_start_o(ee_start),
        .lock_i(lock), .sig_det_i(sig), .horizontal_eye_opening_i(horizontal_eye_opening), .vertical_eye_opening_i(vertical_eye_opening),
        .cdr_reset_o(cdr_rst), .cdr_restart_o(restart), .adapt_mode_o(adapt),
        .irq_n_o(irq_n), .irq_n_oe_o(irq_oe));

    rtm_ee_model u_ee (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ee_start_i(ee_start), .lat_i(lat), .ee_done_o(ee_done));

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        if (ee_start === 1'b1) starts++;
    end

    task automatic nxt;
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
    endtask

    function automatic logic eye_hit(input logic [3:0] h, input logic [3:0] v, input logic [7:0] t);
        return (h < t[7:4]) || (v < t[3:0]);
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr = a;
        wdata = d;
        reg_wr_i = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge clk_sys_i);
        addr = a;
        reg_rd_i = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
        chk({7'h00, rvalid}, 8'h01);
        rd_val = rdata;
        chk(rd_val & m, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic do_reset;
        rstn_i = 1'b0;
        idle(6);
        rstn_i = 1'b1;
        idle(4);
    endtask

    task automatic end_sim;
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #(50 * 40000);
        mismatches++;
        end_sim();
    end

    initial begin
        rng = 32'h6f4c;
        {reg_wr_i, reg_rd_i, addr, wdata} = '0;
        role_strap = 1'b1;
        req_n = 1'b1;
        lat = 4'h0;
        {lock, sig, horizontal_eye_opening, vertical_eye_opening} = '1;
        mismatches = 0;
        n_tests = 0;
        starts = 0;
        do_reset();
        rdc(SH_REV_ID, 8'hff, ID_VAL);
        rdc(8'h77, 8'hff, 8'h00);
        rdc(SH_CTRL, 8'hff, 8'h00);
        rdc(SH_STAT, 8'hff, 8'h00);
        req_n = 1'b0;
        idle(12);
        chk(8'(starts), 8'h01);
        rdc(SH_STAT, 8'h10, 8'h10);
        req_n = 1'b1;
        wr(SH_CTRL, 8'h10);
        idle(8);
        chk(8'(starts), 8'h01);
        wr(SH_CTRL, 8'h20);
        idle(3);
        rdc(SH_CTRL, 8'hff, 8'h20);
        rdc(SH_STAT, 8'h10, 8'h00);
        lat = 4'h9;
        wr(SH_CTRL, 8'h10);
        idle(14);
        chk(8'(starts), 8'h02);
        rdc(SH_STAT, 8'h10, 8'h10);
        wr(SH_CTRL, 8'h20);
        wr(SH_CTRL, 8'h00);
        wr(SH_STAT, 8'h80);
        req_n = 1'b0;
        idle(8);
        chk(8'(starts), 8'h02);
        rdc(SH_STAT, 8'h80, 8'h80);
        wr(SH_CTRL, 8'h40);
        rdc(SH_CTRL, 8'hff, 8'h00);
        rdc(SH_STAT, 8'h80, 8'h00);
        idle(6);
        chk(8'(starts), 8'h03);
        role_strap = 1'b0;
        req_n = 1'b1;
        do_reset();
        wr(SH_CTRL, 8'h10);
        idle(6);
        chk(8'(starts), 8'h04);
        for (int k = 0; k < 6; k++) begin
            nxt();
            ch = rng[1:0];
            wr(SH_CH_SEL, {5'h00, 1'b1, ch});
            wr(CH_ADAPT, {1'b0, rng[6:5], 5'h00});
            wr(CH_CDROVR, 8'h0c);
            idle(1);
            chk({7'h00, cdr_rst[ch]}, 8'h01);
            chk({6'h00, adapt[2*ch+:2]}, {6'h00, rng[6:5]});
            rs = 0;
            wr(CH_CDROVR, 8'h08);
            repeat (4) begin
                @(negedge clk_sys_i);
                if (restart[ch] === 1'b1) rs++;
            end
            chk(8'(rs), 8'h01);
            chk({7'h00, cdr_rst[ch]}, 8'h00);
            rdc(CH_CDROVR, 8'hff, 8'h08);
            lock[ch] = 1'b0;
            sig[ch] = rng[8];
            idle(5);
            chk({6'h00, irq_n, irq_oe}, 8'h01);
            wr(SH_CH_SEL, 8'h00);
            rdc(SH_STAT, 8'h0f, 8'h01 << ch);
            wr(SH_CH_SEL, {5'h00, 1'b1, ch});
            rdc(CH_LSIRQ, 8'h11, {3'h0, 1'b1, 3'h0, ~rng[8]});
            rdc(CH_LSIRQ, 8'h11, 8'h00);
            idle(2);
            chk({7'h00, irq_oe}, 8'h00);
            lock[ch] = 1'b1;
            sig[ch] = 1'b1;
            nxt();
            horizontal_eye_opening[4*ch+:4] = rng[3:0];
            vertical_eye_opening[4*ch+:4] = rng[7:4];
            wr(CH_EYETHR, rng[15:8]);
            idle(2);
            rdc(CH_EYEST, 8'h10, 8'h00);
            wr(CH_EYEEN, 8'h40);
            wr(CH_EYEEN, 8'h00);
            rdc(CH_EYEST, 8'h10, {3'h0, eye_hit(rng[3:0], rng[7:4], rng[15:8]), 4'h0});
            rdc(CH_EYEST, 8'h10, 8'h00);
            idle(2);
            chk({7'h00, irq_oe}, 8'h00);
            wr(CH_SRST, 8'h04);
            rdc(CH_SRST, 8'hff, 8'h00);
            rdc(CH_ADAPT, 8'hff, 8'h00);
            rdc(CH_CDROVR, 8'hff, 8'h00);
            chk({6'h00, adapt[2*ch+:2]}, 8'h00);
        end
        end_sim();
    end
endmodule // tb_top
